// file: retimer_ctrl_checker.sv
// Assertion checker for the lane input control block.
// Assumes it is bound to the block; one core clock domain.
`timescale 1ns/100ps
module retimer_ctrl_checker #(
    parameter int unsigned CDR_ACQ_CYCLES = 200,
    parameter int unsigned ERR_W = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Inputs watched
    input wire logic chip_enable_i,
    input wire logic [retimer_ctrl_pkg::DATA_LANES-1:0] lane_err_i,
    // Outputs watched
    input wire retimer_ctrl_pkg::ctrl_t ctrl_o,
    input wire retimer_ctrl_pkg::cfg_t cfg_o,
    input wire logic [retimer_ctrl_pkg::DATA_LANES-1:0][ERR_W-1:0] err_count_o
);
    import retimer_ctrl_pkg::*;
    localparam int ACQ_LIM = CDR_ACQ_CYCLES + 8;
    localparam int OFF_LIM = CDR_OFF_CYC;
    localparam logic [7:0] REMAP =
        {SRC_IN_LANE_2, SRC_IN_CLK, SRC_IN_LANE_0, SRC_IN_LANE_1};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_hiz_disabled:
        assert property (!chip_enable_i [*6] |->
            ctrl_o == '0 && err_count_o == '0)
        else $error("outputs not cleared while disabled");
    a_oe_after_en:
        assert property ($rose(ctrl_o.main_link_oe) |->
            $past(chip_enable_i, 2) && $past(chip_enable_i, 3))
        else $error("link driven before enable");
    a_oe_when_en:
        assert property (chip_enable_i [*7] |-> ctrl_o.main_link_oe)
        else $error("link not driven after enable");
    a_acq_bound:
        assert property ($rose(ctrl_o.cdr_power) |-> ##[1:ACQ_LIM]
            (ctrl_o.cdr_active || !ctrl_o.cdr_power))
        else $error("recovery not active in time");
    a_redrive_off:
        assert property ((cfg_o.function_mode_select == FM_REDRIVE) [*2]
            |-> !ctrl_o.cdr_power && !ctrl_o.retime_mode)
        else $error("recovery still on in redrive");
    a_cdr_off:
        assert property ($fell(ctrl_o.retime_mode) |-> ##[0:OFF_LIM]
            !ctrl_o.cdr_power)
        else $error("recovery not off after retiming");
    a_remap_route:
        assert property (cfg_o.lane_remap && chip_enable_i ##1
            ctrl_o.main_link_oe && cfg_o.lane_remap |->
            ctrl_o.route == REMAP)
        else $error("remap route wrong");
    a_pol_retime:
        assert property (ctrl_o.polarity_invert |-> ctrl_o.retime_mode)
        else $error("polarity outside retiming");
    a_adapt_retime:
        assert property (ctrl_o.eq_adaptive |-> ctrl_o.retime_mode)
        else $error("adaptive eq outside retiming");
    for (genvar i = 0; i < DATA_LANES; i++)
    begin : g_err
        a_err_step:
            assert property (lane_err_i[i] && chip_enable_i &&
                ctrl_o.main_link_oe && err_count_o[i] != '1 |=>
                err_count_o[i] == $past(err_count_o[i]) + 1'b1)
            else $error("error count did not step");
    end
    c_retime: cover property ($rose(ctrl_o.cdr_active));
    c_remap: cover property (ctrl_o.main_link_oe && ctrl_o.route == REMAP);
    c_err: cover property (lane_err_i != '0 && ctrl_o.main_link_oe);
endmodule

bind retimer_lane_input_control retimer_ctrl_checker #(
    .CDR_ACQ_CYCLES(CDR_ACQ_CYCLES),
    .ERR_W(ERR_W)
) chk_u (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .chip_enable_i(chip_enable_i),
    .lane_err_i(lane_err_i),
    .ctrl_o(ctrl_o),
    .cfg_o(cfg_o),
    .err_count_o(err_count_o)
);

// file: retimer_ctrl_pkg.sv
// Constants and shared types of the retimer lane input control block.
// Assumes a 200 MHz core clock; all counts below except RATE_WIN_CYC derive from it.
package retimer_ctrl_pkg;

    // Core clock rate
    localparam int unsigned CORE_CLK_MHZ = 200;

    // CDR start-up limit after retimer mode entry
    localparam int unsigned CDR_ACQ_MAX_MS = 15;
    localparam int unsigned CDR_ACQ_CYC = CDR_ACQ_MAX_MS * 1000 * CORE_CLK_MHZ;
    localparam int unsigned CDR_ACQ_W = 22;

    // CDR turn-off limit after retimer mode ends (rounded down)
    localparam int unsigned CDR_OFF_MAX_NS = 120;
    localparam int unsigned CDR_OFF_CYC = CDR_OFF_MAX_NS * CORE_CLK_MHZ / 1000;

    // Pixel clock rate detector
    localparam int unsigned RETIME_PIX_MHZ = 100;
    localparam int unsigned PIX_DIV = 16;
    localparam int unsigned RATE_WIN_W = 12;
    localparam int unsigned RATE_WIN_CYC = 1 << RATE_WIN_W;
    localparam int unsigned RATE_EDGE_W = 13;
    localparam int unsigned RATE_EDGE_THR =
        RETIME_PIX_MHZ * RATE_WIN_CYC / (PIX_DIV * CORE_CLK_MHZ);

    // Function mode select codes
    localparam logic [1:0] FM_AUTO = 2'h0;
    localparam logic [1:0] FM_REDRIVE = 2'h1;
    localparam logic [1:0] FM_RETIME = 2'h2;

    // Fixed equalizer gain codes
    localparam int unsigned EQ_GAIN_W = 5;
    localparam logic [4:0] EQ_GAIN_14DB = 5'h0e;
    localparam logic [4:0] EQ_GAIN_7P5DB = 5'h07;

    // Input source codes for the output lane selectors
    localparam logic [1:0] SRC_IN_LANE_0 = 2'h0;
    localparam logic [1:0] SRC_IN_LANE_1 = 2'h1;
    localparam logic [1:0] SRC_IN_LANE_2 = 2'h2;
    localparam logic [1:0] SRC_IN_CLK = 2'h3;

    // Error counters
    localparam int unsigned ERR_CNT_W = 16;
    localparam int unsigned DATA_LANES = 3;

    // Software configuration, cleared by an enable toggle
    typedef struct packed {
        logic lane_remap;
        logic polarity_invert;
        logic eq_adaptive;
        logic [EQ_GAIN_W-1:0] eq_gain;
        logic [1:0] function_mode_select;
    } cfg_t;

    // Strap pins as sampled
    typedef struct packed {
        logic remap_pin_fitted;
        logic lane_remap_polarity_strap;
        logic equalizer_mode_strap;
        logic equalizer_strap_float;
    } strap_t;

    // Source select of each fixed output lane
    typedef struct packed {
        logic [1:0] output_clk_src;
        logic [1:0] output_lane_2_src;
        logic [1:0] output_lane_1_src;
        logic [1:0] output_lane_0_src;
    } route_t;

    // Control outputs towards the analog lanes
    typedef struct packed {
        logic main_link_oe;
        route_t route;
        logic polarity_invert;
        logic retime_mode;
        logic cdr_power;
        logic cdr_active;
        logic eq_adaptive;
        logic [EQ_GAIN_W-1:0] eq_gain;
    } ctrl_t;

    // Mode sequencer states
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_REDRIVE = 4'h2,
        ST_ACQUIRE = 4'h4,
        ST_RETIME = 4'h8
    } mode_state_t;

endpackage

// file: retimer_lane_input_control.sv
// Lane input control: enable sequencing, CDR timing, lane remap,
// polarity, equalizer selection and per-lane input error counting.
// Assumes straps, enable, lock and link clock are asynchronous pins;
// config writes and error strobes come from core clock logic.
`timescale 1ns/100ps
module retimer_lane_input_control #(
    parameter int unsigned CDR_ACQ_CYCLES = retimer_ctrl_pkg::CDR_ACQ_CYC,
    parameter int unsigned ERR_W = retimer_ctrl_pkg::ERR_CNT_W
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Device pins
    input wire logic chip_enable_i,
    input wire retimer_ctrl_pkg::strap_t strap_i,
    input wire logic link_clk_i,
    input wire logic cdr_lock_i,
    // Configuration from the serial control block
    input wire logic cfg_wr_i,
    input wire retimer_ctrl_pkg::cfg_t cfg_i,
    // Input error strobes, one per data lane
    input wire logic [retimer_ctrl_pkg::DATA_LANES-1:0] lane_err_i,
    // Lane control
    output retimer_ctrl_pkg::ctrl_t ctrl_o,
    output retimer_ctrl_pkg::cfg_t cfg_o,
    // Error counts
    output logic [retimer_ctrl_pkg::DATA_LANES-1:0][ERR_W-1:0] err_count_o
);
    import retimer_ctrl_pkg::*;

    typedef struct packed {
        logic en_s1;
        logic en_s2;
        strap_t strap_s1;
        strap_t strap_s2;
        logic lclk_s1;
        logic lclk_s2;
        logic lclk_s3;
        logic lock_s1;
        logic lock_s2;
        logic cfg_valid;
        cfg_t cfg;
        logic [RATE_WIN_W-1:0] win_cnt;
        logic [RATE_EDGE_W-1:0] edge_cnt;
        logic fast;
        mode_state_t state;
        logic [CDR_ACQ_W-1:0] acq_cnt;
        ctrl_t out;
    } top_state_t;

    localparam logic [CDR_ACQ_W-1:0] ACQ_LAST =
        CDR_ACQ_W'(CDR_ACQ_CYCLES - 1);
    localparam logic [RATE_EDGE_W-1:0] EDGE_THR = RATE_EDGE_W'(RATE_EDGE_THR);

    top_state_t s_q;
    top_state_t s_d;

    logic enabled;
    logic link_edge;
    logic [RATE_EDGE_W-1:0] edges_now;
    logic [1:0] mode_sel;
    logic retime_req;
    logic retiming;
    logic remap;
    logic pol_req;
    logic adaptive_sel;
    logic [EQ_GAIN_W-1:0] fixed_gain;

    always_comb
    begin
        s_d = s_q;

        // Two-stage synchronisers for all pins
        s_d.en_s1 = chip_enable_i;
        s_d.en_s2 = s_q.en_s1;
        s_d.strap_s1 = strap_i;
        s_d.strap_s2 = s_q.strap_s1;
        s_d.lclk_s1 = link_clk_i;
        s_d.lclk_s2 = s_q.lclk_s1;
        s_d.lclk_s3 = s_q.lclk_s2;
        s_d.lock_s1 = cdr_lock_i;
        s_d.lock_s2 = s_q.lock_s1;

        enabled = s_q.en_s2;

        // Software writes only count while enabled
        if (cfg_wr_i)
        begin
            s_d.cfg_valid = 1'b1;
            s_d.cfg = cfg_i;
        end

        link_edge = s_q.lclk_s2 && !s_q.lclk_s3;
        edges_now = s_q.edge_cnt;
        if (link_edge && !(&s_q.edge_cnt))
        begin
            edges_now = s_q.edge_cnt + 1'b1;
        end
        s_d.win_cnt = s_q.win_cnt + 1'b1;
        s_d.edge_cnt = edges_now;
        if (&s_q.win_cnt)
        begin
            s_d.fast = (edges_now >= EDGE_THR);
            s_d.edge_cnt = '0;
        end

        mode_sel = s_q.cfg_valid ? s_q.cfg.function_mode_select : FM_AUTO;
        case (mode_sel)
            FM_REDRIVE:
                retime_req = 1'b0;
            FM_RETIME:
                retime_req = 1'b1;
            default:
                retime_req = s_q.fast;
        endcase

        // Mode sequencer
        case (s_q.state)
            ST_OFF:
            begin
                s_d.state = ST_REDRIVE;
            end
            ST_REDRIVE:
            begin
                if (retime_req)
                begin
                    s_d.state = ST_ACQUIRE;
                    s_d.acq_cnt = '0;
                end
            end
            ST_ACQUIRE:
            begin
                if (!retime_req)
                begin
                    s_d.state = ST_REDRIVE;
                end
                else if (s_q.lock_s2 || s_q.acq_cnt == ACQ_LAST)
                begin
                    s_d.state = ST_RETIME;
                end
                else
                begin
                    s_d.acq_cnt = s_q.acq_cnt + 1'b1;
                end
            end
            ST_RETIME:
            begin
                if (!retime_req)
                begin
                    s_d.state = ST_REDRIVE;
                end
            end
            default:
            begin
                s_d.state = ST_OFF;
            end
        endcase

        retiming = (s_d.state == ST_RETIME);

        remap = (s_q.strap_s2.remap_pin_fitted &&
                 !s_q.strap_s2.lane_remap_polarity_strap) ||
                (s_q.cfg_valid && s_q.cfg.lane_remap);

        pol_req = (s_q.strap_s2.remap_pin_fitted &&
                   s_q.strap_s2.lane_remap_polarity_strap) ||
                  (s_q.cfg_valid && s_q.cfg.polarity_invert);

        adaptive_sel = s_q.cfg_valid ? s_q.cfg.eq_adaptive :
                       s_q.strap_s2.equalizer_strap_float;

        if (s_q.cfg_valid)
        begin
            fixed_gain = s_q.cfg.eq_gain;
        end
        else if (s_q.strap_s2.equalizer_mode_strap &&
                 !s_q.strap_s2.equalizer_strap_float)
        begin
            fixed_gain = EQ_GAIN_14DB;
        end
        else
        begin
            fixed_gain = EQ_GAIN_7P5DB;
        end

        s_d.out.main_link_oe = 1'b1;
        s_d.out.retime_mode = retiming;

        if (remap)
        begin
            s_d.out.route.output_clk_src = SRC_IN_LANE_2;
            s_d.out.route.output_lane_2_src = SRC_IN_CLK;
            s_d.out.route.output_lane_1_src = SRC_IN_LANE_0;
            s_d.out.route.output_lane_0_src = SRC_IN_LANE_1;
        end
        else
        begin
            s_d.out.route.output_clk_src = SRC_IN_CLK;
            s_d.out.route.output_lane_2_src = SRC_IN_LANE_2;
            s_d.out.route.output_lane_1_src = SRC_IN_LANE_1;
            s_d.out.route.output_lane_0_src = SRC_IN_LANE_0;
        end

        s_d.out.polarity_invert = pol_req && retiming;

        s_d.out.cdr_power = (s_d.state == ST_ACQUIRE) || retiming;
        s_d.out.cdr_active = retiming;

        // adaptive needs retimer
        // Fixed gain still valid so fallback keeps a sane equalizer
        s_d.out.eq_adaptive = adaptive_sel && retiming;
        s_d.out.eq_gain = fixed_gain;

        if (!enabled)
        begin
            s_d.cfg_valid = 1'b0;
            s_d.cfg = '0;
            s_d.win_cnt = '0;
            s_d.edge_cnt = '0;
            s_d.fast = 1'b0;
            s_d.acq_cnt = '0;
            s_d.state = ST_OFF;
            s_d.out = '0;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
            s_q.state <= ST_OFF;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ctrl_o = s_q.out;
    assign cfg_o = s_q.cfg;

    for (genvar i = 0; i < DATA_LANES; i++)
    begin : g_err
        sat_counter #(
            .WIDTH(ERR_W)
        ) u_err_cnt (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .clr_i(!s_q.en_s2),
            .inc_i(lane_err_i[i]),
            .count_o(err_count_o[i])
        );
    end
endmodule

// file: retimer_lane_input_control_tb_top.sv
// Self-checking bench for the lane input control block.
// Assumes the checker is bound in and the source model drives the link.
`timescale 1ns/100ps
module retimer_lane_input_control_tb_top;
    import retimer_ctrl_pkg::*;
    localparam int EN_LOW_CYC = 20000;
    localparam logic [7:0] NORM =
        {SRC_IN_CLK, SRC_IN_LANE_2, SRC_IN_LANE_1, SRC_IN_LANE_0};
    localparam logic [7:0] REMAP =
        {SRC_IN_LANE_2, SRC_IN_CLK, SRC_IN_LANE_0, SRC_IN_LANE_1};
    logic clk, rst, en, wr_s, lock, run, lclk;
    logic [2:0] lerr;
    logic [4:0] g;
    logic [2:0][15:0] errc;
    logic [15:0] n [3];
    logic [65:0] q [$];
    logic [65:0] ent;
    strap_t strap;
    cfg_t cfg, cfgq, c;
    ctrl_t ctrl;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    integer seed;

    video_source_model src_u (
        .run_i(run),
        .link_clk_o(lclk)
    );
    retimer_lane_input_control #(
        .CDR_ACQ_CYCLES(200),
        .ERR_W(16)
    ) dut_u (
        .core_clk_i(clk),
        .sys_rst_i(rst),
        .chip_enable_i(en),
        .strap_i(strap),
        .link_clk_i(lclk),
        .cdr_lock_i(lock),
        .cfg_wr_i(wr_s),
        .cfg_i(cfg),
        .lane_err_i(lerr),
        .ctrl_o(ctrl),
        .cfg_o(cfgq),
        .err_count_o(errc)
    );

    function automatic ctrl_t mk(logic rt, logic [7:0] r, logic p,
        logic [4:0] gn);
        mk = '{1'b1, route_t'(r), p, rt, rt, rt, 1'b0, gn};
    endfunction

    function automatic logic [63:0] obs(logic [1:0] s);
        case (s)
            2'h0: obs = 64'(ctrl);
            2'h1: obs = 64'(cfgq);
            2'h2: obs = 64'(errc);
            default: obs = 64'(ctrl.eq_adaptive);
        endcase
    endfunction

    task automatic check(logic [63:0] seen, logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic note(logic [1:0] s, logic [63:0] v);
        q.push_back({s, v});
    endtask

    task automatic wr(cfg_t cv);
        cfg = cv;
        wr_s = 1'b1;
        cyc(1);
        wr_s = 1'b0;
    endtask

    // Bounded wait; a hang shows up as a mismatch later
    task automatic wait_act(logic v);
        int k;
        k = 0;
        while (ctrl.cdr_active !== v && k < 9000)
        begin
            cyc(1);
            k++;
        end
        cyc(2);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(negedge clk)
    begin
        while (q.size() > 0)
        begin
            ent = q.pop_front();
            check(obs(ent[65:64]), ent[63:0]);
        end
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_count++;
            final_report();
        end
    end

    initial
    begin
        seed = 32'h2f7e48af;
        {rst, en, wr_s, lock, run} = 5'h10;
        strap = 4'he;
        cfg = '0;
        lerr = '0;
        n = '{default: '0};
        cyc(4);
        rst = 1'b0;
        wr(cfg_t'('1));
        cyc(3);
        note(1, 64'h0);
        note(0, 64'h0);
        cyc(EN_LOW_CYC);
        en = 1'b1;
        cyc(7);
        note(0, 64'(mk(0, NORM, 0, EQ_GAIN_14DB)));
        run = 1'b1;
        wait_act(1);
        note(0, 64'(mk(1, NORM, 1, EQ_GAIN_14DB)));
        strap = 4'h0;
        lock = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            g = 5'($random(seed));
            c = '{m[0], 1'b1, 1'b0, g, 2'(m)};
            wr(c);
            wait_act(m != 1);
            note(1, 64'(c));
            note(0, 64'(mk(m != 1, m[0] ? REMAP : NORM, m != 1, g)));
        end
        wr('{1'b0, 1'b1, 1'b1, g, FM_RETIME});
        wait_act(1);
        note(3, 64'h1);
        wr('{1'b0, 1'b1, 1'b0, g, FM_AUTO});
        run = 1'b0;
        wait_act(0);
        note(0, 64'(mk(0, NORM, 0, g)));
        repeat (40)
        begin
            lerr = 3'($random(seed));
            for (int i = 0; i < 3; i++)
                n[i] += 16'(lerr[i]);
            cyc(1);
        end
        lerr = '0;
        cyc(2);
        note(2, 64'({n[2], n[1], n[0]}));
        en = 1'b0;
        cyc(7);
        note(0, 64'h0);
        note(2, 64'h0);
        strap = 4'h8;
        cyc(EN_LOW_CYC);
        en = 1'b1;
        cyc(7);
        note(1, 64'h0);
        note(0, 64'(mk(0, REMAP, 0, EQ_GAIN_7P5DB)));
        // Floating equalizer strap only shows once retiming
        strap = 4'h9;
        run = 1'b1;
        wait_act(1);
        note(3, 64'h1);
        note(0, 64'(mk(1, REMAP, 0, EQ_GAIN_7P5DB)) | 64'h20);
        cyc(2);
        final_report();
    end
endmodule

// file: sat_counter.sv
// Saturating event counter with synchronous clear.
// Assumes inc_i and clr_i are on the core clock.
`timescale 1ns/100ps
module sat_counter #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic clr_i,
    input wire logic inc_i,
    // Count
    output logic [WIDTH-1:0] count_o
);
    import retimer_ctrl_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_t;

    cnt_state_t s_q;
    cnt_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (clr_i)
        begin
            s_d.count = '0;
        end
        // Holds at full scale so a bad link never wraps to a low count
        else if (inc_i && !(&s_q.count))
        begin
            s_d.count = s_q.count + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign count_o = s_q.count;
endmodule

// file: video_source_model.sv
// Video source model: drives the divided pixel clock of the link.
// Assumes run_i comes from the bench; clock rests low when stopped.
`timescale 1ns/100ps
module video_source_model (
    // Control
    input wire logic run_i,
    // Link
    output logic link_clk_o
);
    initial
    begin
        link_clk_o = 1'b0;
        #7;
        forever
        begin
            #32;
            link_clk_o = run_i ? ~link_clk_o : 1'b0;
        end
    end
endmodule
